// *** design/asr_pkg.sv ***
// Package with register map, field layout and timing constants of the status/threshold bank.
package asr_pkg;
  // Register indexes; byte address is four times the index.
  localparam logic [5:0] IDX_POS_THR = 6'h10;
  localparam logic [5:0] IDX_NEG_THR = 6'h12;
  localparam logic [5:0] IDX_STATUS = 6'h14;
  localparam logic [5:0] IDX_TICK = 6'h15;
  localparam logic [5:0] IDX_DRIFT = 6'h16;
  localparam logic [5:0] IDX_RSVD_A = 6'h1C;
  localparam logic [5:0] IDX_RSVD_B = 6'h1D;
  localparam logic [5:0] IDX_CTRL = 6'h20;
  // Control register fields.
  localparam int CTRL_LOCK_BIT = 0;
  localparam int CTRL_MODE_LSB = 1;
  // Status register bit positions.
  localparam int ST_IDE = 6;
  localparam int ST_MODULATOR_OVERRANGE = 5;
  localparam int ST_INIT = 4;
  localparam int ST_MISO = 3;
  localparam int ST_ZERO = 2;
  localparam int ST_DRIFT = 1;
  localparam int ST_RESET = 0;
  // Reset values.
  localparam logic [7:0] THR_RST = 8'h00;
  localparam logic [7:0] TICK_RST = 8'h00;
  localparam logic [7:0] DRIFT_RST = 8'h00;
  localparam logic [7:0] STATUS_RST = 8'h11;
  localparam logic [2:0] CRC_SEED = 3'h7;
  // Timing: one tick every 128 us at a 25 ns clock period.
  localparam int CLK_PERIOD_NS = 25;
  localparam int TICK_PERIOD_NS = 128000;
  localparam int TICK_CYC = TICK_PERIOD_NS / CLK_PERIOD_NS;
  // Arming modes as seen by the arming logic.
  typedef enum logic [1:0] {
    ARM_OFF = 2'h0,
    ARM_MODE_A = 2'h1,
    ARM_MODE_B = 2'h2,
    ARM_MODE_C = 2'h3
  } asr_arm_mode_t;
endpackage

// *** design/asr_regs.sv ***
// Arming threshold, device status, tick counter and drift correction register bank on APB.
//
// Our own choice: the APB slave port.
`timescale 1ns/1ps
// Behaviour
// - Threshold writes ignored once init lock set.
// - Both thresholds covered by writable CRC.
// - Thresholds are independent unsigned 8-bit values.
// - Zero threshold disables only that polarity.
// - Both zero disables arming and output pin.
// - Status read-only; reads clear transient flags.
// - Status bit 7 meaningless; reads zero.
// - Internal error flag set on faults, read-cleared.
// - Writable CRC fault re-asserts until reset.
// - Modulator overrange flag set, read-cleared.
// - Init flag held until init completes.
// - Serial output mismatch flag, read-cleared.
// - Drift limit flag set, read-cleared.
// - Reset flag set during init, read-cleared.
// - Read-only free-running 8-bit tick counter.
// - Drift correction register returns latest step.
// - Shadow array 3-bit CRC, seed 111.
// - Writable CRC runs only while locked.
module asr_regs #(
  parameter int OTP_W = 24,
  parameter int unsigned TICK_CYCLES = asr_pkg::TICK_CYC
) (
  // APB clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Device events.
  input wire logic init_done,
  input wire logic modulator_sat,
  input wire logic miso_mismatch,
  input wire logic drift_limit,
  input wire logic other_fault,
  input wire logic [7:0] drift_corr_in,
  // Shadow array and its stored check value.
  input wire logic [OTP_W-1:0] otp_shadow,
  input wire logic [2:0] otp_crc,
  // Arming configuration outputs.
  output logic [7:0] pos_threshold,
  output logic [7:0] neg_threshold,
  output logic pos_cmp_en,
  output logic neg_cmp_en,
  output logic arm_pin_en,
  output logic [1:0] arm_mode
);
  localparam int WR_W = 18;

  logic [31:0] prdata_ff;
  logic pready_ff;
  logic pslverr_ff;
  logic [7:0] pos_ff;
  logic [7:0] neg_ff;
  logic lock_ff;
  logic chk_en_ff;
  logic [1:0] mode_ff;
  logic [7:0] status_ff;
  logic [7:0] nxt_status;
  logic [12:0] pre_ff;
  logic [7:0] tick_ff;
  logic [7:0] drift_ff;
  logic [2:0] crc_ref_ff;
  logic wr_err_ff;
  logic fuse_err_ff;
  logic pos_en_ff;
  logic neg_en_ff;
  logic arm_en_ff;
  logic [1:0] arm_mode_ff;
  logic [5:0] idx;
  logic aligned;
  logic setup;
  logic wr_done;
  logic rd_done;
  logic [31:0] rd_mux;
  logic mapped;
  logic [WR_W-1:0] wr_data;
  logic [2:0] wr_crc;

  // Serial CRC with g(x) = x^3 + x + 1 over the low len bits, LSB first.
  function automatic logic [2:0] crc3(input logic [31:0] d, input int len);
    logic [2:0] c;
    logic fb;
    c = asr_pkg::CRC_SEED;
    for (int i = 0; i < 32; i++) begin
      if (i < len) begin
        fb = c[2] ^ d[i];
        c = {c[1], c[0] ^ fb, fb};
      end
    end
    return c;
  endfunction

  // Address decode and transfer qualification.
  assign idx = paddr[7:2];
  assign aligned = (paddr[1:0] == 2'h0);
  assign setup = psel & ~penable;
  assign wr_done = psel & penable & pready_ff & pwrite;
  assign rd_done = psel & penable & pready_ff & ~pwrite;

  // Read multiplexer; bits above the register width read zero.
  always_comb begin
    rd_mux = 32'h0000_0000;
    mapped = aligned;
    case (idx)
      asr_pkg::IDX_POS_THR: rd_mux[7:0] = pos_ff;
      asr_pkg::IDX_NEG_THR: rd_mux[7:0] = neg_ff;
      asr_pkg::IDX_STATUS: rd_mux[7:0] = status_ff;
      asr_pkg::IDX_TICK: rd_mux[7:0] = tick_ff;
      asr_pkg::IDX_DRIFT: rd_mux[7:0] = drift_ff;
      asr_pkg::IDX_RSVD_A: rd_mux[7:0] = 8'h00;
      asr_pkg::IDX_RSVD_B: rd_mux[7:0] = 8'h00;
      asr_pkg::IDX_CTRL: rd_mux[2:0] = {mode_ff, lock_ff};
      default: mapped = 1'b0;
    endcase
  end

  // APB answer: data and ready are prepared in the setup cycle, no wait states.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= 32'h0000_0000;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
    end else begin
      pready_ff <= setup;
      pslverr_ff <= setup & ~mapped;
      if (setup & ~pwrite) begin
        prdata_ff <= mapped ? rd_mux : 32'h0000_0000;
      end
    end
  end

  // Thresholds and control are writable only before the lock is set.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pos_ff <= asr_pkg::THR_RST;
      neg_ff <= asr_pkg::THR_RST;
      mode_ff <= 2'h0;
      lock_ff <= 1'b0;
    end else if (wr_done & aligned & ~lock_ff) begin
      if (idx == asr_pkg::IDX_POS_THR) begin
        pos_ff <= pwdata[7:0];
      end
      if (idx == asr_pkg::IDX_NEG_THR) begin
        neg_ff <= pwdata[7:0];
      end
      if (idx == asr_pkg::IDX_CTRL) begin
        mode_ff <= pwdata[asr_pkg::CTRL_MODE_LSB +: 2];
        lock_ff <= pwdata[asr_pkg::CTRL_LOCK_BIT];
      end
    end
  end

  // Writable array check: reference follows the data until one cycle after locking.
  assign wr_data = {mode_ff, neg_ff, pos_ff};
  assign wr_crc = crc3(32'(wr_data), WR_W);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chk_en_ff <= 1'b0;
      crc_ref_ff <= asr_pkg::CRC_SEED;
      wr_err_ff <= 1'b0;
    end else begin
      chk_en_ff <= lock_ff;
      if (!chk_en_ff) begin
        crc_ref_ff <= wr_crc;
      end
      // The fault is sticky until reset so the flag keeps coming back.
      if (chk_en_ff && wr_crc != crc_ref_ff) begin
        wr_err_ff <= 1'b1;
      end
    end
  end

  // Shadow array check runs continuously, so a fault returns after every reset.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fuse_err_ff <= 1'b0;
    end else begin
      fuse_err_ff <= (crc3(32'(otp_shadow), OTP_W) != otp_crc);
    end
  end

  // Status flags: a read clears only the bits it returned, and a set wins over the clear.
  always_comb begin
    nxt_status = status_ff;
    if (rd_done && aligned && idx == asr_pkg::IDX_STATUS) begin
      nxt_status = status_ff & ~prdata_ff[7:0];
    end
    nxt_status[asr_pkg::ST_INIT] = status_ff[asr_pkg::ST_INIT] & ~init_done;
    if (other_fault | fuse_err_ff | wr_err_ff) begin
      nxt_status[asr_pkg::ST_IDE] = 1'b1;
    end
    if (modulator_sat) begin
      nxt_status[asr_pkg::ST_MODULATOR_OVERRANGE] = 1'b1;
    end
    if (miso_mismatch) begin
      nxt_status[asr_pkg::ST_MISO] = 1'b1;
    end
    if (drift_limit) begin
      nxt_status[asr_pkg::ST_DRIFT] = 1'b1;
    end
    if (status_ff[asr_pkg::ST_INIT]) begin
      nxt_status[asr_pkg::ST_RESET] = 1'b1;
    end
    nxt_status[7] = 1'b0;
    nxt_status[asr_pkg::ST_ZERO] = 1'b0;
  end

  // Reset raises the init and reset-occurred flags.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_ff <= asr_pkg::STATUS_RST;
    end else begin
      status_ff <= nxt_status;
    end
  end

  // Free-running prescaler and tick counter.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_ff <= 13'h0000;
      tick_ff <= asr_pkg::TICK_RST;
    end else if (pre_ff == 13'(TICK_CYCLES - 1)) begin
      pre_ff <= 13'h0000;
      tick_ff <= tick_ff + 8'h01;
    end else begin
      pre_ff <= pre_ff + 13'h0001;
    end
  end

  // Latest offset correction step.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      drift_ff <= asr_pkg::DRIFT_RST;
    end else begin
      drift_ff <= drift_corr_in;
    end
  end

  // Arming enables: a zero threshold turns its polarity off, both zero turn arming off.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pos_en_ff <= 1'b0;
      neg_en_ff <= 1'b0;
      arm_en_ff <= 1'b0;
      arm_mode_ff <= asr_pkg::ARM_OFF;
    end else begin
      pos_en_ff <= (pos_ff != 8'h00);
      neg_en_ff <= (neg_ff != 8'h00);
      arm_en_ff <= (pos_ff != 8'h00) | (neg_ff != 8'h00);
      if (pos_ff == 8'h00 && neg_ff == 8'h00) begin
        arm_mode_ff <= asr_pkg::ARM_OFF;
      end else begin
        arm_mode_ff <= mode_ff;
      end
    end
  end

  // Outputs straight from flip-flops.
  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign pos_threshold = pos_ff;
  assign neg_threshold = neg_ff;
  assign pos_cmp_en = pos_en_ff;
  assign neg_cmp_en = neg_en_ff;
  assign arm_pin_en = arm_en_ff;
  assign arm_mode = arm_mode_ff;

  // Checks of the behaviour above.
  sequence s_pos_write;
    wr_done && aligned && idx == asr_pkg::IDX_POS_THR;
  endsequence

  sequence s_stat_read;
    rd_done && aligned && idx == asr_pkg::IDX_STATUS;
  endsequence

  property p_lock_ignore;
    @(posedge pclk) disable iff (!presetn)
    s_pos_write and lock_ff |=> pos_ff == $past(pos_ff);
  endproperty
  a_lock_ignore: assert property (p_lock_ignore) else $error("threshold changed after lock");

  property p_wr_crc;
    @(posedge pclk) disable iff (!presetn)
    wr_err_ff |=> status_ff[asr_pkg::ST_IDE] [*2];
  endproperty
  a_wr_crc: assert property (p_wr_crc) else $error("writable CRC fault not flagged");

  property p_pos_zero;
    @(posedge pclk) disable iff (!presetn)
    pos_ff == 8'h00 && neg_ff != 8'h00 |=> !pos_cmp_en && neg_cmp_en && arm_pin_en;
  endproperty
  a_pos_zero: assert property (p_pos_zero) else $error("polarity disable wrong");

  property p_both_zero;
    @(posedge pclk) disable iff (!presetn)
    pos_ff == 8'h00 && neg_ff == 8'h00 |=> !arm_pin_en && arm_mode == asr_pkg::ARM_OFF;
  endproperty
  a_both_zero: assert property (p_both_zero) else $error("arming not disabled");

  property p_modulator_overrange_clear;
    @(posedge pclk) disable iff (!presetn)
    s_stat_read and prdata_ff[asr_pkg::ST_MODULATOR_OVERRANGE] && !modulator_sat
      |=> !status_ff[asr_pkg::ST_MODULATOR_OVERRANGE];
  endproperty
  a_modulator_overrange_clear: assert property (p_modulator_overrange_clear) else $error("overrange not cleared");

  property p_init_hold;
    @(posedge pclk) disable iff (!presetn)
    status_ff[asr_pkg::ST_INIT] && !init_done |=> status_ff[asr_pkg::ST_INIT];
  endproperty
  a_init_hold: assert property (p_init_hold) else $error("init flag dropped early");

  property p_bit_zero;
    @(posedge pclk) disable iff (!presetn)
    s_stat_read |-> !prdata_ff[asr_pkg::ST_ZERO];
  endproperty
  a_bit_zero: assert property (p_bit_zero) else $error("status bit 2 not zero");

  property p_tick;
    @(posedge pclk) disable iff (!presetn)
    pre_ff == 13'(TICK_CYCLES - 1) |=> tick_ff == $past(tick_ff) + 8'h01 && pre_ff == 13'h0000;
  endproperty
  a_tick: assert property (p_tick) else $error("tick counter step wrong");

  property p_fuse;
    @(posedge pclk) disable iff (!presetn)
    fuse_err_ff |=> status_ff[asr_pkg::ST_IDE];
  endproperty
  a_fuse: assert property (p_fuse) else $error("shadow CRC fault not flagged");

  property p_miso;
    @(posedge pclk) disable iff (!presetn)
    miso_mismatch |=> status_ff[asr_pkg::ST_MISO];
  endproperty
  a_miso: assert property (p_miso) else $error("mismatch flag not set");
endmodule

// *** tb/asr_master.sv ***
// APB master model standing in for the airbag controller.
`timescale 1ns/1ps
module asr_master (
  // Clock.
  input wire logic pclk,
  // APB request.
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  // APB answer.
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  // The bus is idle at time zero.
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
  end

  // One transfer; the request is held until pready is sampled high.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= ~d; // Stale data is not left on the bus.
  endtask
endmodule

// *** tb/asr_regs_tb.sv ***
// Self-checking bench for the status and threshold register bank.
`timescale 1ns/1ps
module asr_regs_tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e, init_done;
  logic pos_cmp_en, neg_cmp_en, arm_pin_en;
  logic [1:0] arm_mode;
  logic [2:0] otp_crc;
  logic [3:0] ev;
  logic [7:0] paddr, pos_threshold, neg_threshold, drift_corr_in, otp_shadow, t0;
  logic [31:0] pwdata, prdata, r;
  int n_fail = 0;
  int check_count = 0;
  // Status bit expected from each event input, in the order of ev.
  localparam logic [7:0] EVB [4] = '{8'h20, 8'h08, 8'h02, 8'h40};

  // Clock at 40 MHz.
  initial pclk = 1'b0;
  always #12.5 pclk = ~pclk;

  asr_regs #(.OTP_W(8), .TICK_CYCLES(8)) i_asr_regs (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .init_done,
    .modulator_sat(ev[0]), .miso_mismatch(ev[1]), .drift_limit(ev[2]),
    .other_fault(ev[3]), .drift_corr_in, .otp_shadow, .otp_crc, .pos_threshold,
    .neg_threshold, .pos_cmp_en, .neg_cmp_en, .arm_pin_en, .arm_mode);
  asr_master i_asr_master (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr);

  // Reference check value, serial and least significant bit first.
  function automatic logic [2:0] crc3(input logic [7:0] v);
    logic [2:0] c;
    logic fb;
    c = 3'h7;
    for (int i = 0; i < 8; i++) begin
      fb = c[2] ^ v[i];
      c = {c[1], c[0] ^ fb, fb};
    end
    return c;
  endfunction

  // Counts one comparison and reports a mismatch.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Register write and checked read by index.
  task automatic wr(input logic [5:0] idx, input logic [7:0] d);
    i_asr_master.xfer(1'b1, {idx, 2'b00}, {24'h00_0000, d}, r, e);
  endtask
  task automatic rd(input logic [5:0] idx, input logic [7:0] exp);
    i_asr_master.xfer(1'b0, {idx, 2'b00}, 32'h0000_0000, r, e);
    chk(r, {24'h00_0000, exp});
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Main sequence.
  initial begin
    presetn = 1'b0;
    ev = 4'h0;
    init_done = 1'b0;
    drift_corr_in = 8'h00;
    otp_shadow = 8'hA5;
    otp_crc = crc3(8'hA5);
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rd(asr_pkg::IDX_STATUS, 8'h11);
    rd(asr_pkg::IDX_STATUS, 8'h11);
    rd(asr_pkg::IDX_POS_THR, 8'h00);
    rd(asr_pkg::IDX_NEG_THR, 8'h00);
    rd(asr_pkg::IDX_DRIFT, 8'h00);
    rd(asr_pkg::IDX_RSVD_B, 8'h00);
    @(posedge pclk);
    init_done <= 1'b1;
    rd(asr_pkg::IDX_STATUS, 8'h01);
    rd(asr_pkg::IDX_STATUS, 8'h00);
    // One polarity enabled, then both zero.
    wr(asr_pkg::IDX_POS_THR, 8'h64);
    wr(asr_pkg::IDX_NEG_THR, 8'h00);
    rd(asr_pkg::IDX_POS_THR, 8'h64);
    chk({29'h0000_0000, pos_cmp_en, neg_cmp_en, arm_pin_en}, 32'h0000_0005);
    // A requested mode must not survive both thresholds at zero.
    wr(asr_pkg::IDX_CTRL, 8'h04);
    wr(asr_pkg::IDX_POS_THR, 8'h00);
    repeat (2) @(posedge pclk);
    chk({27'h000_0000, pos_cmp_en, neg_cmp_en, arm_pin_en, arm_mode}, 32'h0000_0000);
    // Lock with mode 2 in the same write, then try to change the thresholds.
    wr(asr_pkg::IDX_NEG_THR, 8'h32);
    wr(asr_pkg::IDX_CTRL, 8'h05);
    wr(asr_pkg::IDX_POS_THR, 8'hAA);
    wr(asr_pkg::IDX_NEG_THR, 8'h11);
    rd(asr_pkg::IDX_POS_THR, 8'h00);
    rd(asr_pkg::IDX_NEG_THR, 8'h32);
    chk({16'h0000, pos_threshold, neg_threshold}, 32'h0000_0032);
    chk({27'h000_0000, pos_cmp_en, neg_cmp_en, arm_pin_en, arm_mode}, 32'h0000_000E);
    repeat (4) @(posedge pclk);
    rd(asr_pkg::IDX_STATUS, 8'h00);
    // Writes to read-only and reserved places change nothing.
    wr(asr_pkg::IDX_STATUS, 8'hFF);
    wr(asr_pkg::IDX_DRIFT, 8'hFF);
    wr(asr_pkg::IDX_RSVD_A, 8'h00);
    rd(asr_pkg::IDX_RSVD_A, 8'h00);
    rd(asr_pkg::IDX_STATUS, 8'h00);
    i_asr_master.xfer(1'b0, 8'hFC, 32'h0000_0000, r, e);
    chk(r, 32'h0000_0000);
    chk({31'h0000_0000, e}, 32'h0000_0001);
    // Each event sets its flag once; the next read finds it cleared.
    foreach (EVB[k]) begin
      @(posedge pclk);
      ev[k] <= 1'b1;
      @(posedge pclk);
      ev[k] <= 1'b0;
      rd(asr_pkg::IDX_STATUS, EVB[k]);
      rd(asr_pkg::IDX_STATUS, 8'h00);
    end
    @(posedge pclk);
    drift_corr_in <= 8'h5A;
    rd(asr_pkg::IDX_DRIFT, 8'h5A);
    // Two tick reads whose sampling edges are 32 clocks apart.
    i_asr_master.xfer(1'b0, {asr_pkg::IDX_TICK, 2'b00}, 32'h0000_0000, r, e);
    t0 = r[7:0];
    repeat (29) @(posedge pclk);
    rd(asr_pkg::IDX_TICK, t0 + 8'h04);
    // A bad shadow check value keeps the error flag coming back.
    @(posedge pclk);
    otp_crc <= ~crc3(8'hA5);
    repeat (3) @(posedge pclk);
    rd(asr_pkg::IDX_STATUS, 8'h40);
    rd(asr_pkg::IDX_STATUS, 8'h40);
    // A second reset reopens initialization; the shadow fault outlives it.
    @(posedge pclk);
    presetn <= 1'b0;
    init_done <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(asr_pkg::IDX_STATUS, 8'h11);
    rd(asr_pkg::IDX_STATUS, 8'h51);
    otp_crc <= crc3(8'hA5);
    wr(asr_pkg::IDX_POS_THR, 8'h07);
    rd(asr_pkg::IDX_POS_THR, 8'h07);
    summarize();
  end

  // Watchdog against a hung bus.
  initial begin
    repeat (5000) @(posedge pclk);
    n_fail++;
    summarize();
  end
endmodule
